// ### src/esa_pkg.sv
// Purpose: Constants for the error status, masking and alert block
// Assumes: 8-bit register port, 10 MHz clock
// Notes:   Offsets are byte addresses on the plain register port
package esa_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_HZ          = 10_000_000;
  localparam int unsigned PASS_TIME_MS      = 100;
  localparam int unsigned NUM_SLOTS         = 19;
  // Longest pass time rounds down; each slot gets an equal share
  localparam int unsigned PASS_CYCLES       = (CLOCK_HZ / 1000) * PASS_TIME_MS - 1;
  localparam int unsigned SLOT_CYCLES       = PASS_CYCLES / NUM_SLOTS;

  // ----------------------------------------------------------------
  // Channel layout
  // ----------------------------------------------------------------
  localparam int unsigned NUM_TEMP          = 3;
  localparam int unsigned NUM_VOLT          = 16;
  localparam int unsigned NUM_TACH          = 4;
  localparam int unsigned NUM_GPI           = 8;

  // ----------------------------------------------------------------
  // Limit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] VOLT_HIGH_MASK     = 8'hFF;
  localparam logic [7:0] TEMP_HIGH_MASK     = 8'h80;
  localparam logic [7:0] USER_THR_MASK      = 8'hFF;
  localparam logic [7:0] TACH_LIMIT_MASK    = 8'hFF;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG        = 8'h00;
  localparam logic [7:0] ADDR_STAT_CTRL     = 8'h01;
  localparam logic [7:0] ADDR_SLEEP_STATE   = 8'h02;
  localparam logic [7:0] ADDR_SLEEP_MASK    = 8'h03;
  localparam logic [7:0] ADDR_GPI_MASK      = 8'h04;
  localparam logic [7:0] ADDR_REG_MASK      = 8'h05;
  localparam logic [7:0] ADDR_USER_THR      = 8'h06;
  localparam logic [7:0] ADDR_SLOT          = 8'h07;
  localparam logic [7:0] ADDR_CTRL_STAT0    = 8'h10;
  localparam logic [7:0] ADDR_HOST_STAT0    = 8'h20;
  localparam logic [7:0] ADDR_VOLT_HI0      = 8'h40;
  localparam logic [7:0] ADDR_TEMP_HI0      = 8'h60;
  localparam logic [7:0] ADDR_TACH_LIM0     = 8'h68;

  // ----------------------------------------------------------------
  // Status bank layout: byte index of each event group
  // ----------------------------------------------------------------
  localparam int unsigned STAT_VOLT_LO      = 0;
  localparam int unsigned STAT_VOLT_HI      = 1;
  localparam int unsigned STAT_TEMP         = 2;
  localparam int unsigned STAT_GPI          = 3;
  localparam int unsigned STAT_MISC         = 4;
  localparam int unsigned STAT_THR          = 5;
  localparam int unsigned NUM_STAT          = 6;
  // Bits of the misc byte
  localparam int unsigned MISC_TACH0        = 0;
  localparam int unsigned MISC_TERM0        = 4;
  localparam int unsigned MISC_VRHOT0       = 6;
  // Bits of the throttle byte
  localparam int unsigned THR_USER          = 0;
  localparam int unsigned THR_FIXED0        = 1;

  // ----------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CFG_ALERT_EN      = 0;
  localparam int unsigned STC_ASF_MODE      = 0;
  localparam logic [1:0]  SLEEP_S0          = 2'h0;
  localparam logic [1:0]  SLEEP_S3          = 2'h1;
  localparam logic [1:0]  SLEEP_S45         = 2'h2;
  localparam logic [7:0]  SLEEP_MASK_RESET  = 8'h00;
  // Sleep mask bits: 0 volt, 1 temp, 2 gpi, 3 tach
  localparam int unsigned SMSK_VOLT         = 0;
  localparam int unsigned SMSK_TEMP         = 1;
  localparam int unsigned SMSK_GPI          = 2;
  localparam int unsigned SMSK_TACH         = 3;

endpackage

// ### src/esa_core.sv
// Purpose: Error status banks, masking, alert and measurement slot order
// Assumes: Inputs synchronous to clock; event inputs are live conditions
// Notes:   8-bit registers on a plain address/strobe port
`timescale 1ns/1ps
module esa_core (
  // Clock and resets
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        ext_reset,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  // Live event conditions
  input  wire logic [15:0] volt_low_cond,
  input  wire logic [15:0] volt_high_cond,
  input  wire logic [2:0]  temp_cond,
  input  wire logic [7:0]  gpi_cond,
  input  wire logic [3:0]  tach_cond,
  input  wire logic [1:0]  bus_termination_input,
  input  wire logic [1:0]  regulator_overtemp_input,
  input  wire logic        processor_throttle_activity,
  input  wire logic [1:0]  fixed_throttle_cond,
  // Measurement sequencing
  output logic      [4:0]  sample_slot,
  output logic             slot_start,
  // Error outputs
  output logic             controller_error_output,
  output logic             host_error_output,
  output logic             alert
);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] config_reg;
  logic [7:0] stat_ctrl;
  logic [1:0] sleep_state;
  logic [7:0] sleep_mask;
  logic [7:0] gpi_mask;
  logic [3:0] reg_mask;
  logic [7:0] user_thr;
  logic [7:0] volt_hi   [esa_pkg::NUM_VOLT];
  logic [7:0] temp_hi   [esa_pkg::NUM_TEMP];
  logic [7:0] tach_lim  [esa_pkg::NUM_TACH];
  logic [7:0] ctrl_stat [esa_pkg::NUM_STAT];
  logic [7:0] host_stat [esa_pkg::NUM_STAT];

  always_ff @(posedge clock) begin
    if (rst) begin
      config_reg <= 8'h00;
      stat_ctrl  <= 8'h00;
      sleep_mask <= esa_pkg::SLEEP_MASK_RESET;
      gpi_mask   <= 8'h00;
      reg_mask   <= 4'h0;
      user_thr   <= esa_pkg::USER_THR_MASK;
    end else if (wr) begin
      unique case (addr)
        esa_pkg::ADDR_CONFIG:     config_reg <= wdata;
        esa_pkg::ADDR_STAT_CTRL:  stat_ctrl  <= wdata;
        esa_pkg::ADDR_SLEEP_MASK: sleep_mask <= wdata;
        esa_pkg::ADDR_GPI_MASK:   gpi_mask   <= wdata;
        esa_pkg::ADDR_REG_MASK:   reg_mask   <= wdata[3:0];
        esa_pkg::ADDR_USER_THR:   user_thr   <= wdata;
        default: ;
      endcase
    end
  end

  // Sleep state reset by the external reset only
  always_ff @(posedge clock) begin
    if (ext_reset) begin
      sleep_state <= esa_pkg::SLEEP_S45;
    end else if (wr && addr == esa_pkg::ADDR_SLEEP_STATE) begin
      sleep_state <= wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Limit registers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < esa_pkg::NUM_VOLT; gi++) begin : g_volt
      always_ff @(posedge clock) begin
        if (rst) begin
          volt_hi[gi] <= esa_pkg::VOLT_HIGH_MASK;
        end else if (wr && addr == esa_pkg::ADDR_VOLT_HI0 + 8'(gi)) begin
          volt_hi[gi] <= wdata;
        end
      end
    end
    for (gi = 0; gi < esa_pkg::NUM_TEMP; gi++) begin : g_temp
      always_ff @(posedge clock) begin
        if (rst) begin
          temp_hi[gi] <= esa_pkg::TEMP_HIGH_MASK;
        end else if (wr && addr == esa_pkg::ADDR_TEMP_HI0 + 8'(gi)) begin
          temp_hi[gi] <= wdata;
        end
      end
    end
    for (gi = 0; gi < esa_pkg::NUM_TACH; gi++) begin : g_tach
      always_ff @(posedge clock) begin
        if (rst) begin
          tach_lim[gi] <= esa_pkg::TACH_LIMIT_MASK;
        end else if (wr && addr == esa_pkg::ADDR_TACH_LIM0 + 8'(gi)) begin
          tach_lim[gi] <= wdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Event masking
  // ----------------------------------------------------------------
  logic [7:0] live  [esa_pkg::NUM_STAT];
  logic [7:0] allow [esa_pkg::NUM_STAT];
  logic [7:0] alertable [esa_pkg::NUM_STAT];
  logic       in_s3;
  logic       in_s45;
  logic       sleeping;

  assign in_s3    = (sleep_state == esa_pkg::SLEEP_S3);
  assign in_s45   = (sleep_state == esa_pkg::SLEEP_S45);
  assign sleeping = in_s3 || in_s45;

  always_comb begin
    live[esa_pkg::STAT_VOLT_HI] = volt_low_cond[15:8] | volt_high_cond[15:8];
    live[esa_pkg::STAT_TEMP]    = {5'h00, temp_cond};
    live[esa_pkg::STAT_GPI]     = gpi_cond;
    live[esa_pkg::STAT_MISC]    = {regulator_overtemp_input, bus_termination_input, tach_cond};
    live[esa_pkg::STAT_THR]     = {5'h00, fixed_throttle_cond, processor_throttle_activity};
    // Low voltage byte also carries high errors for channels 0..7
    live[esa_pkg::STAT_VOLT_LO] = volt_low_cond[7:0] | volt_high_cond[7:0];
  end

  // Sleep states: S4/S5 always masks voltages and tach; S3 masks tach
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      allow[esa_pkg::STAT_VOLT_LO][i] = volt_hi[i] != esa_pkg::VOLT_HIGH_MASK;
      allow[esa_pkg::STAT_VOLT_HI][i] = volt_hi[i+8] != esa_pkg::VOLT_HIGH_MASK;
      allow[esa_pkg::STAT_GPI][i]     = !gpi_mask[i];
      allow[esa_pkg::STAT_TEMP][i]    = 1'b0;
      allow[esa_pkg::STAT_MISC][i]    = 1'b0;
      allow[esa_pkg::STAT_THR][i]     = 1'b0;
    end
    for (int i = 0; i < esa_pkg::NUM_TEMP; i++) begin
      allow[esa_pkg::STAT_TEMP][i] = temp_hi[i] != esa_pkg::TEMP_HIGH_MASK;
    end
    for (int i = 0; i < esa_pkg::NUM_TACH; i++) begin
      allow[esa_pkg::STAT_MISC][esa_pkg::MISC_TACH0+i] =
        tach_lim[i] != esa_pkg::TACH_LIMIT_MASK;
    end
    for (int i = 0; i < 2; i++) begin
      allow[esa_pkg::STAT_MISC][esa_pkg::MISC_TERM0+i]  = !reg_mask[i];
      allow[esa_pkg::STAT_MISC][esa_pkg::MISC_VRHOT0+i] = !reg_mask[i+2];
      allow[esa_pkg::STAT_THR][esa_pkg::THR_FIXED0+i]   = 1'b1;
    end
    allow[esa_pkg::STAT_THR][esa_pkg::THR_USER] = user_thr != esa_pkg::USER_THR_MASK;
    // Unconditional sleep masking
    if (in_s45) begin
      allow[esa_pkg::STAT_VOLT_LO] = 8'h00;
      allow[esa_pkg::STAT_VOLT_HI] = 8'h00;
    end
    if (sleeping) begin
      allow[esa_pkg::STAT_MISC][3:0] = 4'h0;
    end
    // Optional sleep masking
    if (sleeping) begin
      if (sleep_mask[esa_pkg::SMSK_VOLT]) begin
        allow[esa_pkg::STAT_VOLT_LO] = 8'h00;
        allow[esa_pkg::STAT_VOLT_HI] = 8'h00;
      end
      if (sleep_mask[esa_pkg::SMSK_TEMP]) begin
        allow[esa_pkg::STAT_TEMP] = 8'h00;
      end
      if (sleep_mask[esa_pkg::SMSK_GPI]) begin
        allow[esa_pkg::STAT_GPI] = 8'h00;
      end
      if (sleep_mask[esa_pkg::SMSK_TACH]) begin
        allow[esa_pkg::STAT_MISC][3:0] = 4'h0;
      end
    end
    for (int b = 0; b < esa_pkg::NUM_STAT; b++) begin
      alertable[b] = 8'hFF;
    end
    alertable[esa_pkg::STAT_THR] = 8'h01;
  end

  // ----------------------------------------------------------------
  // Status banks
  // ----------------------------------------------------------------
  logic       asf_mode;
  logic [7:0] ctrl_any;
  logic [7:0] host_any;
  assign asf_mode = stat_ctrl[esa_pkg::STC_ASF_MODE];

  generate
    for (gi = 0; gi < esa_pkg::NUM_STAT; gi++) begin : g_stat
      logic       ctrl_hit;
      logic       host_hit;
      logic [7:0] set_v;
      logic [7:0] ctrl_clr;
      logic [7:0] host_clr;
      assign ctrl_hit = addr == esa_pkg::ADDR_CTRL_STAT0 + 8'(gi);
      assign host_hit = addr == esa_pkg::ADDR_HOST_STAT0 + 8'(gi);
      assign set_v    = live[gi] & allow[gi];
      // Clear only bits whose cause is gone; set wins
      assign ctrl_clr = ((wr && ctrl_hit) ? wdata : 8'h00)
                      | ((rd && ctrl_hit && asf_mode) ? 8'hFF : 8'h00);
      assign host_clr = (wr && host_hit) ? wdata : 8'h00;
      always_ff @(posedge clock) begin
        if (rst) begin
          ctrl_stat[gi] <= 8'h00;
        end else begin
          // Sticky; mask only blocks new sets
          ctrl_stat[gi] <= (ctrl_stat[gi] & ~(ctrl_clr & ~live[gi])) | set_v;
        end
      end
      always_ff @(posedge clock) begin
        if (rst) begin
          host_stat[gi] <= 8'h00;
        end else begin
          host_stat[gi] <= (host_stat[gi] & ~(host_clr & ~live[gi])) | set_v;
        end
      end
      assign ctrl_any[gi] = |(ctrl_stat[gi] & alertable[gi]);
      assign host_any[gi] = |(host_stat[gi] & alertable[gi]);
    end
    for (gi = esa_pkg::NUM_STAT; gi < 8; gi++) begin : g_pad
      assign ctrl_any[gi] = 1'b0;
      assign host_any[gi] = 1'b0;
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (rst) begin
      controller_error_output <= 1'b0;
      host_error_output       <= 1'b0;
      alert                   <= 1'b0;
    end else begin
      controller_error_output <= |ctrl_any;
      host_error_output       <= |host_any;
      alert <= config_reg[esa_pkg::CFG_ALERT_EN] && (|ctrl_any || |host_any);
    end
  end

  // ----------------------------------------------------------------
  // Round-robin measurement slots
  // ----------------------------------------------------------------
  logic [19:0] slot_cnt;
  always_ff @(posedge clock) begin
    if (rst) begin
      slot_cnt    <= 20'h00000;
      sample_slot <= 5'h01;
      slot_start  <= 1'b0;
    end else if (slot_cnt == 20'(esa_pkg::SLOT_CYCLES - 1)) begin
      slot_cnt    <= 20'h00000;
      slot_start  <= 1'b1;
      // Slots 1-2 diodes, 3 internal, 4-19 voltages
      sample_slot <= (sample_slot == 5'(esa_pkg::NUM_SLOTS)) ? 5'h01 : sample_slot + 5'h01;
    end else begin
      slot_cnt   <= slot_cnt + 20'h00001;
      slot_start <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= 8'h00;
      if (addr == esa_pkg::ADDR_CONFIG) rdata <= config_reg;
      if (addr == esa_pkg::ADDR_STAT_CTRL) rdata <= stat_ctrl;
      if (addr == esa_pkg::ADDR_SLEEP_STATE) rdata <= {6'h00, sleep_state};
      if (addr == esa_pkg::ADDR_SLEEP_MASK) rdata <= sleep_mask;
      if (addr == esa_pkg::ADDR_GPI_MASK) rdata <= gpi_mask;
      if (addr == esa_pkg::ADDR_REG_MASK) rdata <= {4'h0, reg_mask};
      if (addr == esa_pkg::ADDR_USER_THR) rdata <= user_thr;
      if (addr == esa_pkg::ADDR_SLOT) rdata <= {3'h0, sample_slot};
      for (int i = 0; i < esa_pkg::NUM_STAT; i++) begin
        if (addr == esa_pkg::ADDR_CTRL_STAT0 + 8'(i)) rdata <= ctrl_stat[i];
        if (addr == esa_pkg::ADDR_HOST_STAT0 + 8'(i)) rdata <= host_stat[i];
      end
      for (int i = 0; i < esa_pkg::NUM_VOLT; i++) begin
        if (addr == esa_pkg::ADDR_VOLT_HI0 + 8'(i)) rdata <= volt_hi[i];
      end
      for (int i = 0; i < esa_pkg::NUM_TEMP; i++) begin
        if (addr == esa_pkg::ADDR_TEMP_HI0 + 8'(i)) rdata <= temp_hi[i];
      end
      for (int i = 0; i < esa_pkg::NUM_TACH; i++) begin
        if (addr == esa_pkg::ADDR_TACH_LIM0 + 8'(i)) rdata <= tach_lim[i];
      end
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_alert_needs_en: assert property (@(posedge clock) disable iff (rst)
    alert |-> $past(config_reg[esa_pkg::CFG_ALERT_EN]))
    else $error("Alert without enable");
  a_ext_reset_sleep: assert property (@(posedge clock)
    ext_reset |=> sleep_state == esa_pkg::SLEEP_S45)
    else $error("Sleep state not forced");
  a_stat_sticky: assert property (@(posedge clock) disable iff (rst)
    (ctrl_stat[0][0] && !(wr && addr == esa_pkg::ADDR_CTRL_STAT0) && !rd) |=> ctrl_stat[0][0])
    else $error("Controller status bit lost");
  a_stat_hold_live: assert property (@(posedge clock) disable iff (rst)
    (host_stat[0][0] && live[0][0]) |=> host_stat[0][0])
    else $error("Host status cleared while active");
  a_volt_mask: assert property (@(posedge clock) disable iff (rst)
    (volt_hi[0] == esa_pkg::VOLT_HIGH_MASK && !ctrl_stat[0][0]) |=> !ctrl_stat[0][0])
    else $error("Masked voltage set status");
  a_temp_mask: assert property (@(posedge clock) disable iff (rst)
    (temp_hi[0] == esa_pkg::TEMP_HIGH_MASK && !host_stat[2][0]) |=> !host_stat[2][0])
    else $error("Masked temperature set status");
  a_fixed_thr_set: assert property (@(posedge clock) disable iff (rst)
    fixed_throttle_cond[0] |=> ctrl_stat[esa_pkg::STAT_THR][esa_pkg::THR_FIXED0])
    else $error("Fixed throttle bit not set");
  a_slot_wrap: assert property (@(posedge clock) disable iff (rst)
    slot_start |-> sample_slot == (($past(sample_slot) == 5'(esa_pkg::NUM_SLOTS)) ? 5'h01
      : $past(sample_slot) + 5'h01))
    else $error("Slot order broken");
  // Cycles since the last slot advance
  logic [19:0] slot_gap;
  always_ff @(posedge clock) begin
    slot_gap <= (rst || slot_start) ? 20'h00000 : slot_gap + 20'h00001;
  end
  a_slot_period: assert property (@(posedge clock) disable iff (rst)
    slot_gap <= 20'(esa_pkg::SLOT_CYCLES))
    else $error("Slot period too long");
  a_asf_read_clr: assert property (@(posedge clock) disable iff (rst)
    (asf_mode && rd && addr == esa_pkg::ADDR_CTRL_STAT0 + 8'(esa_pkg::STAT_GPI)
      && !live[esa_pkg::STAT_GPI][0]) |=> !ctrl_stat[esa_pkg::STAT_GPI][0])
    else $error("Read did not clear in legacy mode");

endmodule // esa_core

// ### tb/esa_host.sv
// Purpose: Register port master standing in for the controller
// Assumes: One access at a time, strobes one cycle long
// Notes:   Idle address is inverted after each access, and data after writes, to expose stale use
`timescale 1ns/1ps
module esa_host (
  // Clock
  input  wire logic       clock,
  // Register port
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  input  wire logic [7:0] rdata
);
  initial begin
    addr  = 8'h00;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask

  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd   <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask
endmodule // esa_host

// ### tb/esa_core_test.sv
// Purpose: Self-checking bench for the status, mask and alert block
// Assumes: Register reset values as in the package
// Notes:   Runs one measurement slot only
`timescale 1ns/1ps
module esa_core_test;
  logic        clock = 1'b0;
  logic        rst, ext_reset, thr, ctl_err, hst_err, alert, wr, rd, slot_start;
  logic [15:0] v_lo, v_hi;
  logic [7:0]  gpi, addr, wdata, rdata;
  logic [3:0]  tach;
  logic [2:0]  temp;
  logic [1:0]  term, vrh, fthr;
  logic [4:0]  sample_slot;
  int          miscompares = 0;
  int          total_checks = 0;
  int          n;
  int          cyc;

  always #50 clock = ~clock;

  // Cycles since reset release
  always @(posedge clock) cyc <= rst ? 0 : cyc + 1;

  esa_host i_esa_host (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                       .rdata(rdata));
  esa_core i_esa_core (.clock(clock), .rst(rst), .ext_reset(ext_reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .volt_low_cond(v_lo),
    .volt_high_cond(v_hi), .temp_cond(temp), .gpi_cond(gpi), .tach_cond(tach),
    .bus_termination_input(term), .regulator_overtemp_input(vrh),
    .processor_throttle_activity(thr), .fixed_throttle_cond(fthr),
    .sample_slot(sample_slot), .slot_start(slot_start),
    .controller_error_output(ctl_err), .host_error_output(hst_err), .alert(alert));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_esa_host.read(a, d);
    chk8(d, e);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    i_esa_host.write(a, d);
  endtask

  // Same status byte in both banks
  task automatic both(input logic [7:0] i, input logic [7:0] e);
    rchk(esa_pkg::ADDR_CTRL_STAT0 + i, e);
    rchk(esa_pkg::ADDR_HOST_STAT0 + i, e);
  endtask

  task automatic clr(input logic [7:0] i, input logic [7:0] v);
    wreg(esa_pkg::ADDR_CTRL_STAT0 + i, v);
    wreg(esa_pkg::ADDR_HOST_STAT0 + i, v);
  endtask

  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic summarize;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    {rst, ext_reset, thr, v_lo, v_hi, gpi, tach, temp, term, vrh, fthr} = '0;
    rst = 1'b1;
    ext_reset = 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    ext_reset <= 1'b0;
    #1;
    chk8({3'h0, sample_slot}, 8'h01);
    rchk(esa_pkg::ADDR_SLEEP_STATE, 8'h02);
    rchk(esa_pkg::ADDR_VOLT_HI0 + 8'h0F, 8'hFF);
    rchk(esa_pkg::ADDR_TEMP_HI0 + 8'h02, 8'h80);
    rchk(esa_pkg::ADDR_TACH_LIM0, 8'hFF);
    rchk(esa_pkg::ADDR_USER_THR, 8'hFF);
    rchk(8'hFF, 8'h00);
    // Limit masking with live cause, then sleep masking
    @(posedge clock) v_hi <= 16'h0001;
    settle;
    clr(8'h00, 8'h01);
    both(8'h00, 8'h00);
    wreg(esa_pkg::ADDR_VOLT_HI0, 8'h80);
    settle;
    both(8'h00, 8'h00);
    wreg(esa_pkg::ADDR_SLEEP_STATE, {6'h0, esa_pkg::SLEEP_S0});
    settle;
    both(8'h00, 8'h01);
    chk1(alert, 1'b0);
    wreg(esa_pkg::ADDR_CTRL_STAT0, 8'h01);
    rchk(esa_pkg::ADDR_CTRL_STAT0, 8'h01);
    @(posedge clock) v_hi <= 16'h0000;
    settle;
    both(8'h00, 8'h01);
    wreg(esa_pkg::ADDR_CTRL_STAT0, 8'h00);
    rchk(esa_pkg::ADDR_CTRL_STAT0, 8'h01);
    wreg(esa_pkg::ADDR_CONFIG, 8'h01);
    settle;
    chk1(alert, 1'b1);
    chk1(ctl_err, 1'b1);
    chk1(hst_err, 1'b1);
    wreg(esa_pkg::ADDR_VOLT_HI0, 8'hFF);
    both(8'h00, 8'h01);
    wreg(esa_pkg::ADDR_CTRL_STAT0, 8'h01);
    rchk(esa_pkg::ADDR_CTRL_STAT0, 8'h00);
    rchk(esa_pkg::ADDR_HOST_STAT0, 8'h01);
    chk1(ctl_err, 1'b0);
    chk1(hst_err, 1'b1);
    wreg(esa_pkg::ADDR_HOST_STAT0, 8'h01);
    settle;
    chk1(alert, 1'b0);
    // Legacy mode: controller bank clears on read
    wreg(esa_pkg::ADDR_STAT_CTRL, 8'h01);
    rchk(esa_pkg::ADDR_STAT_CTRL, 8'h01);
    @(posedge clock) gpi <= 8'h01;
    @(posedge clock) gpi <= 8'h00;
    settle;
    rchk(esa_pkg::ADDR_CTRL_STAT0 + 8'h03, 8'h01);
    rchk(esa_pkg::ADDR_CTRL_STAT0 + 8'h03, 8'h00);
    rchk(esa_pkg::ADDR_HOST_STAT0 + 8'h03, 8'h01);
    clr(8'h03, 8'h01);
    wreg(esa_pkg::ADDR_STAT_CTRL, 8'h00);
    wreg(esa_pkg::ADDR_GPI_MASK, 8'h01);
    @(posedge clock) gpi <= 8'h03;
    settle;
    gpi <= 8'h00;
    both(8'h03, 8'h02);
    clr(8'h03, 8'h02);
    wreg(esa_pkg::ADDR_SLEEP_STATE, {6'h0, esa_pkg::SLEEP_S3});
    wreg(esa_pkg::ADDR_SLEEP_MASK, 8'h04);
    wreg(esa_pkg::ADDR_TACH_LIM0, 8'h10);
    @(posedge clock) gpi <= 8'h04;
    tach <= 4'h3;
    settle;
    gpi <= 8'h00;
    both(8'h03, 8'h00);
    both(8'h04, 8'h00);
    wreg(esa_pkg::ADDR_SLEEP_STATE, {6'h0, esa_pkg::SLEEP_S0});
    settle;
    tach <= 4'h0;
    both(8'h04, 8'h01);
    clr(8'h04, 8'h01);
    wreg(esa_pkg::ADDR_REG_MASK, 8'h05);
    @(posedge clock) {term, vrh, temp} <= {2'h3, 2'h3, 3'h1};
    settle;
    {term, vrh, temp} <= '0;
    both(8'h04, 8'hA0);
    both(8'h02, 8'h00);
    clr(8'h04, 8'hA0);
    @(posedge clock) {thr, fthr} <= {1'b1, 2'h3};
    settle;
    chk1(alert, 1'b0);
    chk1(ctl_err, 1'b0);
    chk1(hst_err, 1'b0);
    {thr, fthr} <= '0;
    both(8'h05, 8'h06);
    // External reset alone forces the sleep state again
    @(posedge clock) ext_reset <= 1'b1;
    @(posedge clock) ext_reset <= 1'b0;
    rchk(esa_pkg::ADDR_SLEEP_STATE, {6'h00, esa_pkg::SLEEP_S45});
    n = 0;
    while (slot_start !== 1'b1 && n < 60000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 60000) begin
      miscompares++;
      $display("wrong value at %0t: no slot advance", $time);
    end
    chk8({3'h0, sample_slot}, 8'h02);
    chk1((cyc * esa_pkg::NUM_SLOTS) < (esa_pkg::CLOCK_HZ / 1000 * esa_pkg::PASS_TIME_MS), 1'b1);
    summarize;
  end
endmodule // esa_core_test
